/* File: hdl/usb_host_consts.vh */
`ifndef USB_HOST_CONSTS_VH
`define USB_HOST_CONSTS_VH
// Notes on behaviour
// - low page bits 7..1 give table base bits 15..9; bit 0 reads zero.
// - table base is 512-byte aligned; base bits 8..0 are always zero.
// - middle page gives base bits 23..16; read/write, resets to zero.
// - high page gives base bits 31..24 as a full byte.
// - an 11-bit frame number is kept; low byte readable in frame low.
// - frame high is read-only: bits 2..0 frame 10..8, rest zero.
// - in host mode a token write starts a transaction to the address reg.
// - handshake and retry policy come from endpoint zero control.
// - token holds endpoint in bits 7..4 and type in bits 3..0.
// - host 14-bit sof counter reloads with 12000; zero sends sof.
// - at the threshold no new token starts until sof has gone out.
// - sof threshold is an 8-bit byte-time guard, used in host mode only.
// - busy is raised while a token runs; no new token until clear.
// - host select bit together with the enable bit places the controller in host mode.
// - host sends the seven-bit address value with each token.

`define OFF_CONTROL     24'h1c0094
`define OFF_ADDRESS     24'h1c0098
`define OFF_PAGE_LOW    24'h1c009c
`define OFF_FRAME_LOW   24'h1c00a0
`define OFF_FRAME_HIGH  24'h1c00a4
`define OFF_TOKEN       24'h1c00a8
`define OFF_SOF_GUARD   24'h1c00ac
`define OFF_PAGE_MID    24'h1c00b0
`define OFF_PAGE_HIGH   24'h1c00b4
`define OFF_EP0_CTRL    24'h1c00c0

`define RST_BYTE        8'h00
`define RST_BIT         1'b0
`define RST_PAGE_LOW    7'h00
`define RST_FRAME       11'h000

`define CTL_ENABLE_BIT  0
`define CTL_HOST_BIT    3
`define CTL_BUSY_BIT    5
`define ADR_LS_BIT      7
`define EP0_HSHK_BIT    0
`define EP0_NORETRY_BIT 6
`define EP0_NOHUB_BIT   7
`define TABLE_ALIGN_BIT 9

`define PID_OUT         4'h1
`define PID_IN          4'h9
`define PID_SETUP       4'hd

// 12000 bit times at 12 Mbit/s make the 1 ms frame
`define SOF_RELOAD      14'h2ee0
`define BITS_PER_BYTE   8
`endif

/* File: hdl/sof_interval_timer.v */
`timescale 1ns/1ns
`include "usb_host_consts.vh"
module sof_interval_timer #(
  parameter              CNT_W  = 14,
  parameter [CNT_W-1:0]  RELOAD = `SOF_RELOAD
) (
  input  wire            mclk,
  input  wire            rst_n,
  input  wire            run,
  input  wire            bitTick,
  input  wire [7:0]      guardBytes,
  output wire            guard,
  output reg             sofSend
);
  reg  [CNT_W-1:0] count_r;
  wire [CNT_W-1:0] guardBits;

  // guard is counted in byte times, the counter in bit times
  assign guardBits = {{(CNT_W-11){1'b0}}, guardBytes, 3'b000};
  assign guard     = run && (count_r <= guardBits);

  always @(posedge mclk) begin
    if (!rst_n) begin
      count_r <= RELOAD;
      sofSend <= 1'b0;
    end else begin
      sofSend <= 1'b0;
      if (!run) begin
        count_r <= RELOAD;
      end else if (bitTick) begin
        if (count_r == {CNT_W{1'b0}}) begin
          count_r <= RELOAD;
          sofSend <= 1'b1;
        end else begin
          count_r <= count_r - 1'b1;
        end
      end
    end
  end
endmodule // sof_interval_timer

/* File: hdl/token_launcher.v */
`timescale 1ns/1ns
module token_launcher #(
  parameter              CMD_W = 19
) (
  input  wire            mclk,
  input  wire            rst_n,
  input  wire            abort,
  input  wire            writeCmd,
  input  wire [CMD_W-1:0] cmdIn,
  input  wire            hold,
  input  wire            done,
  output reg             busy,
  output reg             start,
  output reg  [CMD_W-1:0] cmdOut
);
  reg pending_r;

  always @(posedge mclk) begin
    if (!rst_n) begin
      busy      <= 1'b0;
      pending_r <= 1'b0;
      start     <= 1'b0;
      cmdOut    <= {CMD_W{1'b0}};
    end else begin
      start <= 1'b0;
      if (abort) begin
        busy      <= 1'b0;
        pending_r <= 1'b0;
      end else if (writeCmd && !busy) begin
        busy      <= 1'b1;
        pending_r <= 1'b1;
        cmdOut    <= cmdIn;
      end else if (pending_r && !hold) begin
        // held back while hold is high: the sof guard window is open or sof is being sent
        pending_r <= 1'b0;
        start     <= 1'b1;
      end else if (done && busy && !pending_r) begin
        busy <= 1'b0;
      end
    end
  end
endmodule // token_launcher

/* File: hdl/usb_host_token_sof_regs.v */
`timescale 1ns/1ns
`include "usb_host_consts.vh"
module usb_host_token_sof_regs #(
  parameter              ADDR_W     = 24,
  parameter              SOF_CNT_W  = 14,
  parameter [SOF_CNT_W-1:0] SOF_RELOAD = `SOF_RELOAD
) (
  input  wire            mclk,
  input  wire            rst_n,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]     pwdata,
  output wire [31:0]     prdata,
  output wire            pready,
  output wire            pslverr,
  input  wire            bitTick,
  input  wire            tokenDone,
  output wire            tokenStart,
  output wire [3:0]      tokenType,
  output wire [3:0]      tokenEndpoint,
  output wire [6:0]      tokenAddress,
  output wire            tokenLowSpeed,
  output wire            tokenHandshake,
  output wire            tokenRetryOff,
  output wire            tokenDirectLow,
  output wire            tokenBusy,
  output wire            sofSend,
  output wire [10:0]     frameNumber,
  output wire [31:0]     tableBase,
  output wire            hostMode
);

  ////////////////////////////////////////////////////////////////////////
  // register selects

  localparam [3:0] SEL_CONTROL = 4'h0;
  localparam [3:0] SEL_ADDRESS = 4'h1;
  localparam [3:0] SEL_PG_LOW  = 4'h2;
  localparam [3:0] SEL_FR_LOW  = 4'h3;
  localparam [3:0] SEL_FR_HIGH = 4'h4;
  localparam [3:0] SEL_TOKEN   = 4'h5;
  localparam [3:0] SEL_GUARD   = 4'h6;
  localparam [3:0] SEL_PG_MID  = 4'h7;
  localparam [3:0] SEL_PG_HIGH = 4'h8;
  localparam [3:0] SEL_EP0     = 4'h9;
  localparam [3:0] SEL_NONE    = 4'hf;
  localparam       CMD_W       = 19;
  localparam       NUM_REGS    = 10;

  function [3:0] regSelect;
    input [ADDR_W-1:0] a;
    begin
      case (a)
        `OFF_CONTROL:    regSelect = SEL_CONTROL;
        `OFF_ADDRESS:    regSelect = SEL_ADDRESS;
        `OFF_PAGE_LOW:   regSelect = SEL_PG_LOW;
        `OFF_FRAME_LOW:  regSelect = SEL_FR_LOW;
        `OFF_FRAME_HIGH: regSelect = SEL_FR_HIGH;
        `OFF_TOKEN:      regSelect = SEL_TOKEN;
        `OFF_SOF_GUARD:  regSelect = SEL_GUARD;
        `OFF_PAGE_MID:   regSelect = SEL_PG_MID;
        `OFF_PAGE_HIGH:  regSelect = SEL_PG_HIGH;
        `OFF_EP0_CTRL:   regSelect = SEL_EP0;
        default:         regSelect = SEL_NONE;
      endcase
    end
  endfunction

  // pid check is used only by the token write filter
  function pidValid;
    input [3:0] pid;
    begin
      case (pid)
        `PID_OUT:   pidValid = 1'b1;
        `PID_IN:    pidValid = 1'b1;
        `PID_SETUP: pidValid = 1'b1;
        default:    pidValid = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // storage

  reg        usbEnable_r;
  reg        hostSel_r;
  reg [7:0]  address_r;
  reg [6:0]  pageLow_r;
  reg [7:0]  pageMid_r;
  reg [7:0]  pageHigh_r;
  reg [7:0]  token_r;
  reg [7:0]  guard_r;
  reg [7:0]  ep0Ctrl_r;
  reg [10:0] frame_r;
  reg [10:0] frame_nxt;
  reg [31:0] rdData_r;
  reg        slvErr_r;
  reg [7:0]  rdByte;

  wire             setupPhase;
  wire             accessPhase;
  wire             wrAccess;
  wire [3:0]       setupSel;
  wire [3:0]       accessSel;
  wire [7:0]       wByte;
  wire             tokenWrite;
  wire             timerRun;
  wire             guardWin;
  wire             busy;
  wire [CMD_W-1:0] cmdIn;
  wire [CMD_W-1:0] cmdOut;
  wire [NUM_REGS-1:0] wrStrobe;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, read data captured in the setup cycle

  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign pready      = accessPhase;
  assign pslverr     = accessPhase && slvErr_r;
  assign prdata      = rdData_r;
  assign setupSel    = regSelect(paddr);
  assign accessSel   = regSelect(paddr);
  assign wrAccess    = accessPhase && pwrite && !slvErr_r;
  assign wByte       = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////
  // readback

  // read data is latched at setup, so the access phase needs no wait
  always @* begin
    rdByte = 8'h00;
    case (setupSel)
      SEL_CONTROL: begin
        rdByte[`CTL_ENABLE_BIT] = usbEnable_r;
        rdByte[`CTL_HOST_BIT]   = hostSel_r;
        rdByte[`CTL_BUSY_BIT]   = busy;
      end
      SEL_ADDRESS: rdByte = address_r;
      SEL_PG_LOW:  rdByte = {pageLow_r, 1'b0};
      SEL_FR_LOW:  rdByte = frame_r[7:0];
      SEL_FR_HIGH: rdByte = {5'h00, frame_r[10:8]};
      SEL_TOKEN:   rdByte = token_r;
      SEL_GUARD:   rdByte = guard_r;
      SEL_PG_MID:  rdByte = pageMid_r;
      SEL_PG_HIGH: rdByte = pageHigh_r;
      SEL_EP0:     rdByte = ep0Ctrl_r;
      default:     rdByte = 8'h00;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      rdData_r <= 32'h0000_0000;
      slvErr_r <= 1'b0;
    end else if (setupPhase) begin
      // narrow registers sit in the low byte, upper bits read zero
      rdData_r <= {24'h00_0000, rdByte};
      slvErr_r <= (setupSel == SEL_NONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write strobes

  // one decode per select code keeps the register processes plain
  // the frame count strobes stay unused: those registers are read-only
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g = g + 1) begin : gWrStrobe
      assign wrStrobe[g] = wrAccess && ({28'h000_0000, accessSel} == g);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // control and address

  // busy is owned by the launcher, a write clears it only by leaving host mode
  always @(posedge mclk) begin
    if (!rst_n) begin
      usbEnable_r <= `RST_BIT;
      hostSel_r   <= `RST_BIT;
    end else if (wrStrobe[SEL_CONTROL]) begin
      usbEnable_r <= wByte[`CTL_ENABLE_BIT];
      hostSel_r   <= wByte[`CTL_HOST_BIT];
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      address_r <= `RST_BYTE;
    end else if (wrStrobe[SEL_ADDRESS]) begin
      address_r <= wByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // descriptor table pages

  always @(posedge mclk) begin
    if (!rst_n) begin
      pageLow_r <= `RST_PAGE_LOW;
    end else if (wrStrobe[SEL_PG_LOW]) begin
      pageLow_r <= wByte[7:1];
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      pageMid_r <= `RST_BYTE;
    end else if (wrStrobe[SEL_PG_MID]) begin
      pageMid_r <= wByte;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      pageHigh_r <= `RST_BYTE;
    end else if (wrStrobe[SEL_PG_HIGH]) begin
      pageHigh_r <= wByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // threshold and endpoint zero control

  always @(posedge mclk) begin
    if (!rst_n) begin
      guard_r <= `RST_BYTE;
    end else if (wrStrobe[SEL_GUARD]) begin
      guard_r <= wByte;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      ep0Ctrl_r <= `RST_BYTE;
    end else if (wrStrobe[SEL_EP0]) begin
      ep0Ctrl_r <= wByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // token command

  // a write while busy, outside host mode or with a bad pid is dropped
  assign tokenWrite = wrStrobe[SEL_TOKEN]
                      && hostMode && !busy
                      && pidValid(wByte[3:0]);

  always @(posedge mclk) begin
    if (!rst_n) begin
      token_r <= `RST_BYTE;
    end else if (tokenWrite) begin
      token_r <= wByte;
    end
  end

  // address and endpoint zero policy are sampled at the token write
  assign cmdIn = {ep0Ctrl_r[`EP0_NOHUB_BIT],
                  ep0Ctrl_r[`EP0_NORETRY_BIT],
                  ep0Ctrl_r[`EP0_HSHK_BIT],
                  address_r[`ADR_LS_BIT],
                  address_r[6:0],
                  wByte[7:4],
                  wByte[3:0]};

  token_launcher #(
    .CMD_W    (CMD_W)
  ) launcher (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .abort    (!hostMode),
    .writeCmd (tokenWrite),
    .cmdIn    (cmdIn),
    .hold     (guardWin || sofSend),
    .done     (tokenDone),
    .busy     (busy),
    .start    (tokenStart),
    .cmdOut   (cmdOut)
  );

  ////////////////////////////////////////////////////////////////////////
  // token fields

  assign tokenType      = cmdOut[3:0];
  assign tokenEndpoint  = cmdOut[7:4];
  assign tokenAddress   = cmdOut[14:8];
  assign tokenLowSpeed  = cmdOut[15];
  assign tokenHandshake = cmdOut[16];
  assign tokenRetryOff  = cmdOut[17];
  assign tokenDirectLow = cmdOut[18];
  assign tokenBusy      = busy;

  ////////////////////////////////////////////////////////////////////////
  // start-of-frame timing

  assign hostMode = hostSel_r && usbEnable_r;
  // sof stops when the module is disabled or leaves host mode
  assign timerRun = hostMode;

  sof_interval_timer #(
    .CNT_W      (SOF_CNT_W),
    .RELOAD     (SOF_RELOAD)
  ) sofTimer (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .run        (timerRun),
    .bitTick    (bitTick),
    .guardBytes (guard_r),
    .guard      (guardWin),
    .sofSend    (sofSend)
  );

  ////////////////////////////////////////////////////////////////////////
  // frame number

  always @* begin
    frame_nxt = frame_r;
    if (sofSend) begin
      frame_nxt = frame_r + 11'h001;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      frame_r <= `RST_FRAME;
    end else begin
      frame_r <= frame_nxt;
    end
  end

  assign frameNumber = frame_r;

  ////////////////////////////////////////////////////////////////////////
  // descriptor table base

  // bits below the alignment bit are wired to zero, never stored
  assign tableBase = {pageHigh_r, pageMid_r, pageLow_r,
                      {`TABLE_ALIGN_BIT{1'b0}}};

endmodule // usb_host_token_sof_regs

/* File: verif/usb_host_token_sof_regs_props.sv */
`timescale 1ns/1ns
`include "usb_host_consts.vh"
module usb_host_token_sof_regs_props (
  input wire        mclk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [23:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        tokenStart,
  input wire [3:0]  tokenType,
  input wire [3:0]  tokenEndpoint,
  input wire        tokenBusy,
  input wire        sofSend,
  input wire [10:0] frameNumber,
  input wire [31:0] tableBase,
  input wire        hostMode
);
  wire wrAcc = psel && penable && pwrite;
  wire okPid = pwdata[3:0] == `PID_OUT || pwdata[3:0] == `PID_IN ||
               pwdata[3:0] == `PID_SETUP;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence tokWr;
    wrAcc && paddr == `OFF_TOKEN && hostMode && !tokenBusy;
  endsequence
  //////////////////////////////////////////////////////////////////////
  base_align_a: assert property (tableBase[8:0] == 9'h000)
    else $error("table base off boundary");
  page_low_a: assert property (wrAcc && paddr == `OFF_PAGE_LOW |=>
    tableBase[15:9] == $past(pwdata[7:1])) else $error("page low");
  page_mid_a: assert property (wrAcc && paddr == `OFF_PAGE_MID |=>
    tableBase[23:16] == $past(pwdata[7:0])) else $error("page mid");
  page_high_a: assert property (wrAcc && paddr == `OFF_PAGE_HIGH |=>
    tableBase[31:24] == $past(pwdata[7:0])) else $error("page high");
  token_take_a: assert property (tokWr ##0 okPid |=> tokenBusy &&
    {tokenEndpoint, tokenType} == $past(pwdata[7:0]))
    else $error("token not taken");
  bad_pid_a: assert property (tokWr ##0 !okPid |=> !tokenBusy)
    else $error("bad token taken");
  busy_hold_a: assert property (wrAcc && paddr == `OFF_TOKEN &&
    tokenBusy |=> $stable({tokenType, tokenEndpoint}))
    else $error("token overwritten");
  start_busy_a: assert property (tokenStart |-> tokenBusy)
    else $error("start without busy");
  frame_step_a: assert property (sofSend |=>
    frameNumber == $past(frameNumber) + 11'h001) else $error("frame step");
  frame_hold_a: assert property (!sofSend |=> $stable(frameNumber))
    else $error("frame moved");
  frame_high_a: assert property (psel && !penable && !pwrite &&
    paddr == `OFF_FRAME_HIGH |=> prdata == {29'h0, $past(frameNumber[10:8])})
    else $error("frame high read");
  sof_gap_a: assert property (sofSend |=> !sofSend [*8])
    else $error("sof too close");
  host_only_a: assert property (!hostMode ##1 !hostMode |-> !sofSend)
    else $error("sof outside host");
endmodule // usb_host_token_sof_regs_props
bind usb_host_token_sof_regs usb_host_token_sof_regs_props i_props (
  .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .tokenStart, .tokenType, .tokenEndpoint, .tokenBusy, .sofSend,
  .frameNumber, .tableBase, .hostMode);

/* File: verif/usb_peer_model.sv */
`timescale 1ns/1ns
module usb_peer_model #(
  parameter [3:0] DONE_LAG = 4'h3
) (
  input  wire mclk,
  input  wire rst_n,
  input  wire tokenStart,
  output reg  bitTick,
  output reg  tokenDone
);
  reg [3:0] lag_r;
  // a bit time every other clock keeps the frame short in simulation
  always @(posedge mclk) begin
    if (!rst_n) begin
      bitTick   <= 1'b0;
      tokenDone <= 1'b0;
      lag_r     <= 4'h0;
    end else begin
      bitTick   <= !bitTick;
      tokenDone <= (lag_r == 4'h1);
      if (tokenStart)
        lag_r <= DONE_LAG;
      else if (lag_r != 4'h0)
        lag_r <= lag_r - 4'h1;
    end
  end
endmodule // usb_peer_model

/* File: verif/usb_host_token_sof_regs_bench.sv */
`timescale 1ns/1ns
`include "usb_host_consts.vh"
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin failCount++; \
$display("unexpected at %0t: %h not %h", $time, g, e); end end
module usb_host_token_sof_regs_bench;
  localparam int RELOAD = 40;
  reg         mclk, rst_n, psel, penable, pwrite, err, gotSof;
  reg  [23:0] paddr;
  reg  [31:0] pwdata, rdat;
  wire [31:0] prdata, tableBase;
  wire [10:0] frameNumber;
  wire [6:0]  tokenAddress;
  wire [3:0]  tokenType, tokenEndpoint;
  wire        pready, pslverr, bitTick, tokenDone, tokenStart, hostMode;
  wire        tokenLowSpeed, tokenHandshake, tokenRetryOff, tokenDirectLow;
  wire        tokenBusy, sofSend;
  int         failCount = 0, checksDone = 0, cyc = 0, sofs = 0, c0, n;
  bit  [7:0]  tok[3] = '{8'h21, 8'h39, 8'h4d};
  //////////////////////////////////////////////////////////////////////
  usb_host_token_sof_regs #(.SOF_RELOAD(14'h0028)) i_usb_host_token_sof_regs (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bitTick, .tokenDone, .tokenStart, .tokenType,
    .tokenEndpoint, .tokenAddress, .tokenLowSpeed, .tokenHandshake,
    .tokenRetryOff, .tokenDirectLow, .tokenBusy, .sofSend, .frameNumber,
    .tableBase, .hostMode);
  usb_peer_model #(.DONE_LAG(4'h8)) i_usb_peer_model (
    .mclk, .rst_n, .tokenStart, .bitTick, .tokenDone);
  //////////////////////////////////////////////////////////////////////
  task automatic tallyAndFinish;
    if (failCount == 0 && checksDone > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // an idle cycle after each transfer keeps drivers to one change a step
  task automatic apb(input [23:0] a, input w, input [7:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input [23:0] a, input [7:0] e);
    apb(a, 1'b0, 8'h00);
    `CHK(rdat, {24'h000000, e})
  endtask
  task automatic waitSof;
    while (sofSend !== 1'b1) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  task automatic token(input [7:0] t, input [2:0] pol);
    rd(`OFF_CONTROL, 8'h09);
    apb(`OFF_TOKEN, 1'b1, t);
    `CHK(tokenBusy, 1'b1)
    gotSof = 1'b0;
    while (tokenStart !== 1'b1) begin
      gotSof = gotSof | sofSend;
      @(posedge mclk);
    end
    `CHK({tokenEndpoint, tokenType}, t)
    `CHK({tokenLowSpeed, tokenAddress}, 8'h85)
    `CHK({tokenHandshake, tokenRetryOff, tokenDirectLow}, pol)
    rd(`OFF_CONTROL, 8'h29);
    apb(`OFF_TOKEN, 1'b1, 8'hf1);
    `CHK(tokenType, t[3:0])
    while (tokenBusy !== 1'b0) @(posedge mclk);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (sofSend === 1'b1)
      sofs <= sofs + 1;
    if (cyc == 5000) begin
      failCount++;
      tallyAndFinish;
    end
  end
  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 24'h000000;
    pwdata  = 32'h00000000;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(`OFF_FRAME_HIGH, `RST_BYTE);
    rd(`OFF_PAGE_MID, `RST_BYTE);
    apb(`OFF_PAGE_LOW, 1'b1, 8'hff);
    apb(`OFF_PAGE_MID, 1'b1, 8'h5a);
    apb(`OFF_PAGE_HIGH, 1'b1, 8'ha5);
    rd(`OFF_PAGE_LOW, 8'hfe);
    rd(`OFF_PAGE_MID, 8'h5a);
    `CHK(tableBase, 32'ha55afe00)
    apb(`OFF_FRAME_HIGH, 1'b1, 8'h07);
    rd(`OFF_FRAME_HIGH, 8'h00);
    apb(24'h1c0000, 1'b0, 8'h00);
    `CHK({err, rdat}, 33'h100000000)
    apb(`OFF_TOKEN, 1'b1, 8'h19);
    `CHK(tokenBusy, 1'b0)
    apb(`OFF_ADDRESS, 1'b1, 8'h85);
    apb(`OFF_EP0_CTRL, 1'b1, 8'h41);
    apb(`OFF_CONTROL, 1'b1, 8'h09);
    `CHK(hostMode, 1'b1)
    for (n = 0; n < 3; n++)
      token(tok[n], 3'b110);
    apb(`OFF_TOKEN, 1'b1, 8'h25);
    `CHK(tokenBusy, 1'b0)
    waitSof;
    c0 = cyc;
    waitSof;
    `CHK(cyc - c0, 2 * (RELOAD + 1))
    rd(`OFF_FRAME_LOW, sofs[7:0]);
    `CHK(frameNumber, sofs[10:0])
    // threshold sized for the shortened simulation frame
    apb(`OFF_SOF_GUARD, 1'b1, 8'h04);
    apb(`OFF_EP0_CTRL, 1'b1, 8'h80);
    waitSof;
    repeat (20) @(posedge mclk);
    token(8'h19, 3'b001);
    `CHK(gotSof, 1'b1)
    tallyAndFinish;
  end
endmodule // usb_host_token_sof_regs_bench
